// file: logic/aph_pkg.sv
// Constants and types shared by the converter port and its host controller
package aph_pkg;
	// ----------------------------------------
	// Bus layout
	// ----------------------------------------
	localparam int APH_DATA_W = 12;
	localparam int APH_CFG_W = 8;
	localparam int APH_HIGH_W = 4;
	localparam int APH_ACQ_BIT = 5;
	localparam int APH_PWR_HI = 7;
	localparam int APH_PWR_LO = 6;
	localparam int APH_REF_BIT = 4;
	localparam int APH_POL_BIT = 3;
	localparam int APH_CH_HI = 2;
	localparam int APH_CH_LO = 0;
	// ----------------------------------------
	// Power codes
	// ----------------------------------------
	localparam logic [1:0] APH_PWR_FULL_DOWN = 2'h0;
	localparam logic [1:0] APH_PWR_STANDBY = 2'h1;
	localparam logic [1:0] APH_PWR_INT_CLK = 2'h2;
	localparam logic [1:0] APH_PWR_EXT_CLK = 2'h3;
	// ----------------------------------------
	// Timing in nanoseconds and core cycles
	// ----------------------------------------
	localparam int APH_CLK_NS = 4;
	localparam int APH_ACQ_NS = 400;
	localparam int APH_ACQ_CYC = (APH_ACQ_NS + APH_CLK_NS - 1) / APH_CLK_NS;
	localparam int APH_CONV_STEPS = 13;
	localparam int APH_INT_DIV = 4;
	localparam int APH_STROBE_CYC = 4;
	localparam int APH_CNT_W = 8;
	// ----------------------------------------
	// Host register map
	// ----------------------------------------
	localparam int APH_ADDR_W = 4;
	localparam logic [3:0] APH_REG_CTRL = 4'h0;
	localparam logic [3:0] APH_REG_RESULT = 4'h1;
	localparam logic [3:0] APH_REG_STATUS = 4'h2;
	localparam logic [3:0] APH_REG_IRQ = 4'h3;
	localparam logic [3:0] APH_REG_MASK = 4'h4;
	localparam logic [3:0] APH_REG_CFG = 4'h5;
	localparam int APH_IRQ_DONE = 0;
	localparam int APH_IRQ_READ = 1;
	localparam int APH_CTRL_START = 0;
	localparam int APH_CTRL_READ = 1;
	localparam int APH_CTRL_CFG = 2;
	localparam int APH_CTRL_CLK = 3;
	typedef enum logic [2:0] {APH_D_IDLE, APH_D_ACQ, APH_D_HOLD, APH_D_CONV} aph_dev_st_t;
	typedef enum logic [2:0] {APH_H_IDLE, APH_H_WR, APH_H_RD, APH_H_GAP} aph_host_st_t;
endpackage

// file: logic/aph_if.sv
// Pin-level interface between the host controller and the converter port
`timescale 1ns/1ps
interface aph_if;
	import aph_pkg::*;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic conv_clk;
	logic done_n;
	logic [APH_CFG_W-1:0] host_lo;
	logic host_lo_oe;
	logic [APH_CFG_W-1:0] dev_lo;
	logic [APH_HIGH_W-1:0] dev_hi;
	logic dev_oe;
	modport device (input cs_n, rd_n, wr_n, conv_clk, host_lo, host_lo_oe,
		output done_n, dev_lo, dev_hi, dev_oe);
	modport host (output cs_n, rd_n, wr_n, conv_clk, host_lo, host_lo_oe,
		input done_n, dev_lo, dev_hi, dev_oe);
endinterface

// file: logic/aph_edge.sv
// Edge detector for a strobe pin
`timescale 1ns/1ps
module aph_edge
	import aph_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Strobe
	input wire logic sig_in,
	output logic rise_out,
	output logic fall_out
);
	logic last;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last <= 1'h1;
		end else begin
			last <= sig_in;
		end
	end
	assign rise_out = sig_in & ~last;
	assign fall_out = ~sig_in & last;
endmodule

// file: logic/aph_device.sv
// Converter end of the parallel host port
`timescale 1ns/1ps
module aph_device
	import aph_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Link
	aph_if.device link,
	// Analog side: sample value and decoded selections
	input wire logic [APH_DATA_W-1:0] sample_in,
	output logic [2:0] channel_address_out,
	output logic input_reference_select_out,
	output logic polarity_coding_select_out,
	output logic [1:0] power_state_select_out,
	output logic busy_out
);
	aph_dev_st_t state;
	logic [APH_CFG_W-1:0] cfg;
	logic [APH_DATA_W-1:0] result;
	logic [APH_CNT_W-1:0] cnt;
	logic [APH_CNT_W-1:0] steps;
	logic clk_last;
	logic wr_rise, rd_fall;
	logic ext_clk, step;
	logic wr_take, acq_src, conv_go, finish;
	// ----------------------------------------
	// Strobe edges
	// ----------------------------------------
	// Edges show in the same cycle the pin moves, combinationally; every decision below allows for it
	aph_edge u_wr (.clk_in(clk_in), .rst_n_in(rst_n_in), .sig_in(link.wr_n),
		.rise_out(wr_rise), .fall_out());
	aph_edge u_rd (.clk_in(clk_in), .rst_n_in(rst_n_in), .sig_in(link.rd_n),
		.rise_out(), .fall_out(rd_fall));
	// Only the external clock code uses the pin; the host may still toggle it while another code is held here
	assign ext_clk = (cfg[APH_PWR_HI:APH_PWR_LO] == APH_PWR_EXT_CLK);
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clk_last <= 1'h0;
		end else begin
			clk_last <= link.conv_clk;
		end
	end
	// One SAR step per falling edge of the pin clock, or per divider tick inside
	// Pin falls count only in external clock mode, so a stray edge otherwise is harmless
	assign step = ext_clk ? (clk_last & ~link.conv_clk) : (cnt == '0);
	// ----------------------------------------
	// Configuration and sequencing
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg <= {APH_PWR_INT_CLK, 6'h00};
		end else if (state == APH_D_IDLE && !link.cs_n && wr_rise && link.host_lo_oe) begin
			cfg <= link.host_lo;
		end
	end
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	assign wr_take = !link.cs_n && wr_rise;
	// A start without configuration lines uses the source already held
	assign acq_src = link.host_lo_oe ? link.host_lo[APH_ACQ_BIT] : cfg[APH_ACQ_BIT];
	assign conv_go = (state == APH_D_ACQ && cnt == '0) || (state == APH_D_HOLD && wr_take);
	assign finish = (state == APH_D_CONV) && step && (steps == APH_CNT_W'(1));
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= APH_D_IDLE;
		end else begin
			unique case (state)
				APH_D_IDLE: begin
					if (wr_take) begin
						state <= acq_src ? APH_D_HOLD : APH_D_ACQ;
					end
				end
				APH_D_ACQ: begin
					if (cnt == '0) begin
						state <= APH_D_CONV;
					end
				end
				APH_D_HOLD: begin
					// Host picks the sampling instant with a second write
					if (wr_take) begin
						state <= APH_D_CONV;
					end
				end
				APH_D_CONV: begin
					// Write edges here are ignored; spacing them is the host's job
					if (finish) begin
						state <= APH_D_IDLE;
					end
				end
				default: state <= APH_D_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// Counters
	// ----------------------------------------
	// One counter serves acquisition length and then the internal step divider
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= '0;
		end else if (state == APH_D_IDLE && wr_take) begin
			cnt <= APH_CNT_W'(APH_ACQ_CYC - 1);
		end else if (conv_go) begin
			cnt <= APH_CNT_W'(APH_INT_DIV - 1);
		end else if (state == APH_D_ACQ) begin
			cnt <= cnt - 1'b1;
		end else if (state == APH_D_CONV) begin
			cnt <= (cnt == '0) ? APH_CNT_W'(APH_INT_DIV - 1) : cnt - 1'b1;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			steps <= '0;
		end else if (conv_go) begin
			steps <= APH_CNT_W'(APH_CONV_STEPS);
		end else if (state == APH_D_CONV && step) begin
			steps <= steps - 1'b1;
		end
	end
	// ----------------------------------------
	// Result and done flag
	// ----------------------------------------
	// Sample taken on the last step, so the input may settle through the conversion
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			result <= '0;
		end else if (finish) begin
			result <= sample_in;
		end
	end
	// Finish sets the flag low; a read start raises it, finish wins on a tie
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link.done_n <= 1'h1;
		end else if (finish) begin
			link.done_n <= 1'h0;
		end else if ((!link.cs_n && rd_fall) || (state == APH_D_IDLE && wr_take)) begin
			link.done_n <= 1'h1;
		end
	end
	// ----------------------------------------
	// Data bus drive
	// ----------------------------------------
	// Drive follows the pins combinationally so release is immediate on select high
	assign link.dev_oe = !link.cs_n && !link.rd_n;
	assign link.dev_lo = result[APH_CFG_W-1:0];
	assign link.dev_hi = result[APH_DATA_W-1:APH_CFG_W];
	// ----------------------------------------
	// Decoded selections
	// ----------------------------------------
	// Registered copies keep bus activity off the analog selections
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			channel_address_out <= 3'h0;
		end else begin
			channel_address_out <= cfg[APH_CH_HI:APH_CH_LO];
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			input_reference_select_out <= 1'h0;
		end else begin
			input_reference_select_out <= cfg[APH_REF_BIT];
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			polarity_coding_select_out <= 1'h0;
		end else begin
			polarity_coding_select_out <= cfg[APH_POL_BIT];
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			power_state_select_out <= APH_PWR_INT_CLK;
		end else begin
			power_state_select_out <= cfg[APH_PWR_HI:APH_PWR_LO];
		end
	end
	// Busy covers acquisition, the host-timed hold and conversion
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_out <= 1'h0;
		end else begin
			busy_out <= (state != APH_D_IDLE);
		end
	end
	// Rewrite hazard is on the host; a write edge mid-conversion is ignored
endmodule

// file: logic/aph_host.sv
// Host controller end of the parallel host port
`timescale 1ns/1ps
module aph_host
	import aph_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [APH_ADDR_W-1:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic irq_out,
	// Link
	aph_if.host link
);
	aph_host_st_t state;
	logic [APH_CFG_W-1:0] cfg;
	logic [APH_DATA_W-1:0] result;
	logic [1:0] irq_stat, irq_mask;
	logic [APH_CNT_W-1:0] cnt;
	logic clk_run, clk_div, done_last;
	logic go_wr, go_rd, done_ev, read_ev;
	assign go_wr = wr_in && addr_in == APH_REG_CTRL && wdata_in[APH_CTRL_START];
	assign go_rd = wr_in && addr_in == APH_REG_CTRL && wdata_in[APH_CTRL_READ];
	assign done_ev = done_last && !link.done_n;
	assign read_ev = state == APH_H_RD && cnt == '0;
	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg <= {APH_PWR_INT_CLK, 6'h00};
			clk_run <= 1'h0;
		end else if (wr_in && addr_in == APH_REG_CFG) begin
			cfg <= wdata_in[APH_CFG_W-1:0];
			clk_run <= wdata_in[APH_CFG_W];
		end
	end
	// Clock runs only when asked and in external clock mode, else held low
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clk_div <= 1'h0;
			link.conv_clk <= 1'h0;
		end else begin
			clk_div <= ~clk_div;
			if (clk_run && cfg[APH_PWR_HI:APH_PWR_LO] == APH_PWR_EXT_CLK) begin
				link.conv_clk <= clk_div ? ~link.conv_clk : link.conv_clk;
			end else begin
				link.conv_clk <= 1'h0;
			end
		end
	end
	// ----------------------------------------
	// Strobe sequencer
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= APH_H_IDLE;
			cnt <= '0;
			link.cs_n <= 1'h1;
			link.wr_n <= 1'h1;
			link.rd_n <= 1'h1;
			link.host_lo_oe <= 1'h0;
			link.host_lo <= '0;
		end else begin
			unique case (state)
				APH_H_IDLE: begin
					if (go_wr) begin
						state <= APH_H_WR;
						cnt <= APH_CNT_W'(APH_STROBE_CYC - 1);
						link.cs_n <= 1'h0;
						link.wr_n <= 1'h0;
						link.host_lo <= cfg;
						link.host_lo_oe <= wdata_in[APH_CTRL_CFG];
					end else if (go_rd) begin
						state <= APH_H_RD;
						cnt <= APH_CNT_W'(APH_STROBE_CYC - 1);
						link.cs_n <= 1'h0;
						link.rd_n <= 1'h0;
					end
				end
				APH_H_WR: begin
					cnt <= cnt - 1'b1;
					if (cnt == '0) begin
						link.wr_n <= 1'h1;
						state <= APH_H_GAP;
						cnt <= APH_CNT_W'(APH_STROBE_CYC - 1);
					end
				end
				APH_H_RD: begin
					cnt <= cnt - 1'b1;
					if (cnt == '0) begin
						link.rd_n <= 1'h1;
						state <= APH_H_GAP;
						cnt <= APH_CNT_W'(APH_STROBE_CYC - 1);
					end
				end
				APH_H_GAP: begin
					// Guard time keeps select stable past the strobe; the data drive is released after its first cycle
					link.host_lo_oe <= 1'h0;
					cnt <= cnt - 1'b1;
					if (cnt == '0) begin
						link.cs_n <= 1'h1;
						state <= APH_H_IDLE;
					end
				end
				default: state <= APH_H_IDLE;
			endcase
		end
	end
	// Software waits for done before rewriting; that covers the first clock edge
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			result <= '0;
		end else if (read_ev && link.dev_oe) begin
			result <= {link.dev_hi, link.dev_lo};
		end
	end
	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_last <= 1'h1;
			irq_stat <= 2'h0;
			irq_mask <= 2'h0;
			irq_out <= 1'h0;
		end else begin
			done_last <= link.done_n;
			if (wr_in && addr_in == APH_REG_MASK) begin
				irq_mask <= wdata_in[1:0];
			end
			// Set wins over a simultaneous write-one clear
			irq_stat <= (irq_stat & ~((wr_in && addr_in == APH_REG_IRQ) ? wdata_in[1:0] : 2'h0))
				| {read_ev, done_ev};
			irq_out <= |(irq_stat & irq_mask);
		end
	end
	// ----------------------------------------
	// Register read
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 32'h0;
		end else if (rd_in) begin
			unique case (addr_in)
				APH_REG_RESULT: rdata_out <= {20'h0, result};
				APH_REG_STATUS: rdata_out <= {29'h0, state != APH_H_IDLE, !link.done_n, clk_run};
				APH_REG_IRQ: rdata_out <= {30'h0, irq_stat};
				APH_REG_MASK: rdata_out <= {30'h0, irq_mask};
				APH_REG_CFG: rdata_out <= {23'h0, clk_run, cfg};
				default: rdata_out <= 32'h0;
			endcase
		end else begin
			rdata_out <= 32'h0;
		end
	end
endmodule

// file: tb/aph_link_sva.sv
// Concurrent checks on the converter port link
`timescale 1ns/1ps
module aph_link_sva
	import aph_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Link signals
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic conv_clk,
	input wire logic done_n,
	input wire logic [APH_CFG_W-1:0] host_lo,
	input wire logic host_lo_oe,
	input wire logic [APH_CFG_W-1:0] dev_lo,
	input wire logic [APH_HIGH_W-1:0] dev_hi,
	input wire logic dev_oe
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic wr_q;
	logic clk_q;
	logic wr_rise;
	logic clk_fall;
	logic [7:0] cfg_seen;
	logic [7:0] fall_cnt;
	assign wr_rise = wr_n & ~wr_q & ~cs_n;
	assign clk_fall = clk_q & ~conv_clk;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_q <= 1'b1;
			clk_q <= 1'b0;
		end else begin
			wr_q <= wr_n;
			clk_q <= conv_clk;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_seen <= 8'h80;
		end else if (wr_rise && host_lo_oe) begin
			cfg_seen <= host_lo;
		end
	end
	// Saturates so a long run of clock edges cannot wrap it
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fall_cnt <= 8'h00;
		end else if (wr_rise) begin
			fall_cnt <= 8'h00;
		end else if (clk_fall && fall_cnt != 8'hFF) begin
			fall_cnt <= fall_cnt + 8'h01;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_int_start;
		wr_rise && host_lo_oe && host_lo[7:6] == APH_PWR_INT_CLK && !host_lo[APH_ACQ_BIT];
	endsequence
	sequence s_ext_hold;
		wr_rise && host_lo_oe && host_lo[7:6] == APH_PWR_INT_CLK && host_lo[APH_ACQ_BIT];
	endsequence
	sequence s_ext_conv;
		wr_rise && !host_lo_oe && cfg_seen[APH_ACQ_BIT] && cfg_seen[7:6] == APH_PWR_INT_CLK;
	endsequence
	a_release_on_deselect: assert property (cs_n |-> !dev_oe)
		else $error("data bus driven while deselected");
	a_read_drives_bus: assert property (!cs_n && !rd_n |-> dev_oe)
		else $error("read strobe did not enable the data bus");
	a_result_held_steady: assert property (dev_oe && $past(dev_oe) |-> $stable({dev_hi, dev_lo}))
		else $error("result lines changed during a read");
	a_done_clears_read: assert property ($fell(rd_n) && !cs_n && !done_n |-> ##[1:4] done_n)
		else $error("done flag stayed low after read began");
	a_int_conv_done: assert property (s_int_start |-> ##[140:170] !done_n)
		else $error("internal conversion did not finish in time");
	a_ext_acq_holds: assert property (s_ext_hold |-> ##165 done_n)
		else $error("conversion ran without the ending write");
	a_ext_conv_done: assert property (s_ext_conv |-> ##[48:64] !done_n)
		else $error("held sample not converted in time");
	a_ext_clk_paces: assert property ($fell(done_n) && cfg_seen[7:6] == APH_PWR_EXT_CLK
		|-> fall_cnt >= 8'h0D && $past(clk_fall))
		else $error("done before enough conversion clock falls");
endmodule

// file: tb/test_adc_parallel_host_port.sv
// Self-checking bench for the converter port and its host controller
`timescale 1ns/1ps
module test_adc_parallel_host_port;
	import aph_pkg::*;
	logic clk_in;
	logic rst_n_in;
	logic [APH_ADDR_W-1:0] addr;
	logic [31:0] wdata;
	logic wr_s;
	logic rd_s;
	logic [31:0] rdata;
	logic irq;
	logic [APH_DATA_W-1:0] sample;
	logic [2:0] chan;
	logic ref_sel;
	logic pol_sel;
	logic [1:0] pwr;
	logic clk_hold;
	logic busy;
	int num_errors;
	int num_checks;
	aph_if link();
	aph_host aph_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .irq_out(irq),
		.link(link));
	aph_device aph_device_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
		.sample_in(sample), .channel_address_out(chan), .input_reference_select_out(ref_sel),
		.polarity_coding_select_out(pol_sel), .power_state_select_out(pwr), .busy_out(busy));
	aph_link_sva aph_link_sva_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n(link.cs_n),
		.rd_n(link.rd_n), .wr_n(link.wr_n), .conv_clk(link.conv_clk), .done_n(link.done_n),
		.host_lo(link.host_lo), .host_lo_oe(link.host_lo_oe), .dev_lo(link.dev_lo),
		.dev_hi(link.dev_hi), .dev_oe(link.dev_oe));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_in);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		@(negedge clk_in);
		chk(rdata & msk, exp);
	endtask
	// Bounded so a lost event ends as a mismatch, not a hang
	task automatic wait_irq(input int n);
		for (int i = 0; i < n && irq !== 1'b1; i++) begin
			@(negedge clk_in);
		end
		chk({31'h0, irq}, 32'h1);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever begin
			#2 clk_in = ~clk_in;
		end
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		num_errors++;
		report_and_stop;
	end
	initial begin
		rst_n_in = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		sample = 12'hA5C;
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd(APH_REG_CFG, 32'h80, 32'h1FF);
		rd(APH_REG_STATUS, 32'h0, 32'h7);
		rd(4'hF, 32'h0, 32'hFFFFFFFF);
		wr(APH_REG_MASK, 32'h3);
		wr(APH_REG_CFG, 32'h9D);
		wr(APH_REG_CTRL, 32'h5);
		wait_irq(400);
		chk({24'h0, pwr, 1'b0, ref_sel, pol_sel, chan}, 32'h9D);
		chk({31'h0, link.done_n}, 32'h0);
		rd(APH_REG_STATUS, 32'h2, 32'h7);
		rd(APH_REG_IRQ, 32'h1, 32'h3);
		wr(APH_REG_IRQ, 32'h1);
		rd(APH_REG_IRQ, 32'h0, 32'h3);
		chk({31'h0, irq}, 32'h0);
		wr(APH_REG_CTRL, 32'h2);
		wait_irq(100);
		rd(APH_REG_RESULT, 32'hA5C, 32'hFFF);
		chk({31'h0, link.done_n}, 32'h1);
		wr(APH_REG_IRQ, 32'h2);
		// Host-timed sampling, done event masked
		wr(APH_REG_MASK, 32'h0);
		sample <= 12'h3C1;
		wr(APH_REG_CFG, 32'hA2);
		wr(APH_REG_CTRL, 32'h5);
		repeat (200) @(posedge clk_in);
		rd(APH_REG_IRQ, 32'h0, 32'h1);
		chk({31'h0, busy}, 32'h1);
		wr(APH_REG_CTRL, 32'h1);
		repeat (80) @(posedge clk_in);
		rd(APH_REG_IRQ, 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h0);
		chk({29'h0, chan}, 32'h2);
		chk({31'h0, busy}, 32'h0);
		wr(APH_REG_IRQ, 32'h3);
		wr(APH_REG_CTRL, 32'h2);
		repeat (40) @(posedge clk_in);
		rd(APH_REG_RESULT, 32'h3C1, 32'hFFF);
		// Conversion paced by the host clock, then back to internal
		wr(APH_REG_MASK, 32'h1);
		wr(APH_REG_CFG, 32'h1D1);
		wr(APH_REG_CTRL, 32'h5);
		wait_irq(4000);
		chk({30'h0, pwr}, 32'h3);
		wr(APH_REG_IRQ, 32'h3);
		wr(APH_REG_CFG, 32'h80);
		wr(APH_REG_CTRL, 32'h5);
		wait_irq(400);
		clk_hold = link.conv_clk;
		repeat (20) @(posedge clk_in);
		chk({31'h0, link.conv_clk}, {31'h0, clk_hold});
		wr(APH_REG_IRQ, 32'h3);
		// Both power-down codes
		for (int c = 0; c < 2; c++) begin
			wr(APH_REG_CFG, {24'h0, c[1:0], 6'h0});
			wr(APH_REG_CTRL, 32'h5);
			repeat (200) @(posedge clk_in);
			chk({30'h0, pwr}, {30'h0, c[1:0]});
		end
		report_and_stop;
	end
endmodule
